// file: fsp_defines.vh
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define FSP_A_CTRL 8'h00
`define FSP_A_ROWP 8'h04
`define FSP_A_EXPO 8'h08
`define FSP_A_GAIN 8'h0c
`define FSP_A_SLOW 8'h10
`define FSP_A_PLL 8'h14
`define FSP_A_STAT 8'h18
`define FSP_A_LIVE_EXPO 8'h1c
`define FSP_A_LIVE_GAIN 8'h20
`define FSP_A_GALIGN 8'h24
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define FSP_B_FREEZE 15
`define FSP_B_SUPPRESS 9
`define FSP_B_STREAM 2
`define FSP_B_SIX_BIT 4
`define FSP_B_GALIGN 0
`define FSP_F_VT_DIV 7:0
`define FSP_F_OP_DIV 15:8
`define FSP_F_CORE_SLOW 2:0
`define FSP_F_OP_SLOW 10:8
`define FSP_CTRL_RST 16'h0200
`define FSP_SLOW_RST 16'h0101
`define FSP_ROWP_RST 16'h0010
`define FSP_EXPO_RST 16'h0004
`define FSP_GAIN_RST 16'h0010
`define FSP_PLL_RST 16'h0101
`define FSP_ROWS_RST 16'h0008
`define FSP_DARK_ROWS 16'h0002
`endif

// file: fsp_clkdiv.v
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defines.vh"
// ----------------------------------------------------------------
// enable divider: one-cycle pulse every div enabled cycles
// ----------------------------------------------------------------
module fsp_clkdiv #(
   parameter W = 8
) (
   input wire hclk,
   input wire hresetn,
   input wire en,
   input wire [W-1:0] div,
   output reg tick
);
   reg [W-1:0] cnt;
   // divisor of zero treated as one so the chain never stalls
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt <= {W{1'b0}};
         tick <= 1'b0;
      end
      else if (!en)
         tick <= 1'b0;
      else if (cnt + {{(W-1){1'b0}}, 1'b1} >= div)
      begin
         cnt <= {W{1'b0}};
         tick <= 1'b1;
      end
      else
      begin
         cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: fsp_dbuf.v
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defines.vh"
// ----------------------------------------------------------------
// pending/live register pair
// ----------------------------------------------------------------
module fsp_dbuf #(
   parameter W = 16,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire hclk,
   input wire hresetn,
   input wire wr,
   input wire [W-1:0] wdata,
   input wire xfer,
   output reg [W-1:0] pending,
   output reg [W-1:0] live,
   output reg dirty
);
   // a write in the transfer cycle stays pending for the next start
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pending <= RST;
         live <= RST;
         dirty <= 1'b0;
      end
      else
      begin
         if (wr)
            pending <= wdata;
         if (xfer)
            live <= pending;
         dirty <= wr | (dirty & ~xfer);
      end
   end
endmodule
`default_nettype wire

// file: fsp_top.v
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defines.vh"
// ----------------------------------------------------------------
// frame-synchronised parameter update
// ----------------------------------------------------------------
module fsp_top #(
   parameter ROWS_W = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   output wire frame_start,
   output reg row_valid,
   output reg frame_valid_flag,
   output wire video_timing_pixel_clock,
   output wire core_pixel_tick,
   output wire output_pixel_clock,
   output wire output_load_clock,
   output reg word_clock,
   output wire serial_clock_en,
   output reg [15:0] live_row_period,
   output reg [15:0] live_exposure,
   output reg [15:0] live_gain
);
   // ----------------------------------------------------------------
   // bus slave: zero wait states, always okay
   // ----------------------------------------------------------------
   reg wr_pend;
   reg [7:0] wr_addr;
   wire wr_en;
   wire [15:0] wd;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wd = hwdata[15:0];
   assign wr_en = wr_pend;
   // capture the address phase of a write
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend <= hsel & htrans[1] & hwrite;
         wr_addr <= haddr;
      end
   end
   // ----------------------------------------------------------------
   // immediate registers
   // ----------------------------------------------------------------
   reg [15:0] ctrl;
   reg [15:0] slow;
   reg [15:0] pll;
   reg galign;
   // non-synchronised registers take effect at once
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= `FSP_CTRL_RST;
         slow <= `FSP_SLOW_RST;
         pll <= `FSP_PLL_RST;
         galign <= 1'b0;
      end
      else if (wr_en)
      begin
         case (wr_addr)
            `FSP_A_CTRL: ctrl <= wd;
            `FSP_A_SLOW: slow <= wd;
            `FSP_A_PLL: pll <= wd; // divisors meant for standby only
            `FSP_A_GALIGN: galign <= wd[`FSP_B_GALIGN];
            default: ;
         endcase
      end
   end
   wire freeze;
   wire suppress;
   wire streaming;
   assign freeze = ctrl[`FSP_B_FREEZE];
   assign suppress = ctrl[`FSP_B_SUPPRESS];
   assign streaming = ctrl[`FSP_B_STREAM];
   // ----------------------------------------------------------------
   // clock enable chain
   // ----------------------------------------------------------------
   wire vt_pre;
   wire op_pre;
   reg half;
   // video clock runs at half the pll divisor rate, only while streaming
   fsp_clkdiv #(.W(8)) u_vt (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(streaming),
      .div(pll[`FSP_F_VT_DIV]),
      .tick(vt_pre)
   );
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         half <= 1'b0;
      else if (vt_pre)
         half <= ~half;
   end
   assign video_timing_pixel_clock = vt_pre & half;
   wire [2:0] core_div;
   assign core_div = (slow[`FSP_F_CORE_SLOW] == 3'h0) ? 3'h1 : slow[`FSP_F_CORE_SLOW];
   reg [2:0] core_cnt;
   // core clock divides the video clock by the low slowdown field
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         core_cnt <= 3'h0;
      else if (video_timing_pixel_clock)
         core_cnt <= (core_cnt + 3'h1 >= core_div) ? 3'h0 : core_cnt + 3'h1;
   end
   assign core_pixel_tick = video_timing_pixel_clock & (core_cnt + 3'h1 >= core_div);
   fsp_clkdiv #(.W(8)) u_op (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(streaming),
      .div(pll[`FSP_F_OP_DIV]),
      .tick(op_pre)
   );
   assign output_pixel_clock = op_pre;
   wire [2:0] op_div;
   assign op_div = (slow[`FSP_F_OP_SLOW] == 3'h0) ? 3'h1 : slow[`FSP_F_OP_SLOW];
   reg [2:0] op_cnt;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         op_cnt <= 3'h0;
      else if (op_pre)
         op_cnt <= (op_cnt + 3'h1 >= op_div) ? 3'h0 : op_cnt + 3'h1;
   end
   assign output_load_clock = op_pre & (op_cnt + 3'h1 >= op_div);
   assign serial_clock_en = streaming;
   reg word_ph;
   // six-bit packing: two pixels per word, word at half speed
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         word_ph <= 1'b0;
         word_clock <= 1'b0;
      end
      else
      begin
         if (output_load_clock)
            word_ph <= ~word_ph;
         word_clock <= output_load_clock &
            (~ctrl[`FSP_B_SIX_BIT] | word_ph);
      end
   end
   // ----------------------------------------------------------------
   // row and frame timing
   // ----------------------------------------------------------------
   reg [15:0] col_cnt;
   reg [ROWS_W-1:0] row_cnt;
   wire row_end;
   wire frame_end;
   assign row_end = core_pixel_tick &
      (col_cnt + 16'h0001 >= live_row_period); // period in core clocks
   assign frame_end = row_end & (row_cnt + {{(ROWS_W-1){1'b0}}, 1'b1} >= `FSP_ROWS_RST);
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         col_cnt <= 16'h0000;
         row_cnt <= {ROWS_W{1'b0}};
      end
      else if (!streaming)
      begin
         col_cnt <= 16'h0000;
         row_cnt <= {ROWS_W{1'b0}};
      end
      else if (core_pixel_tick)
      begin
         col_cnt <= row_end ? 16'h0000 : col_cnt + 16'h0001;
         if (frame_end)
            row_cnt <= {ROWS_W{1'b0}};
         else if (row_end)
            row_cnt <= row_cnt + {{(ROWS_W-1){1'b0}}, 1'b1};
      end
   end
   // first dark row read at frame row zero
   assign frame_start = frame_end;
   wire xfer;
   assign xfer = frame_start & ~freeze;
   // ----------------------------------------------------------------
   // double-buffered registers
   // ----------------------------------------------------------------
   wire [15:0] rp_pend;
   wire [15:0] rp_live;
   wire rp_dirty;
   wire [15:0] ex_pend;
   wire [15:0] ex_live;
   wire ex_dirty;
   wire [15:0] gn_pend;
   wire gn_dirty;
   fsp_dbuf #(.W(16), .RST(`FSP_ROWP_RST)) u_rowp (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr(wr_en & (wr_addr == `FSP_A_ROWP)),
      .wdata(wd),
      .xfer(xfer),
      .pending(rp_pend),
      .live(rp_live),
      .dirty(rp_dirty)
   );
   fsp_dbuf #(.W(16), .RST(`FSP_EXPO_RST)) u_expo (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr(wr_en & (wr_addr == `FSP_A_EXPO)),
      .wdata(wd),
      .xfer(xfer),
      .pending(ex_pend),
      .live(ex_live),
      .dirty(ex_dirty)
   );
   fsp_dbuf #(.W(16), .RST(`FSP_GAIN_RST)) u_gain (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr(wr_en & (wr_addr == `FSP_A_GAIN)),
      .wdata(wd),
      .xfer(xfer),
      .pending(gn_pend),
      .live(),
      .dirty(gn_dirty)
   );
   // gain stage: held one more frame when exposure moved with it and galign is clear
   reg [15:0] gain_hold;
   reg gain_hold_v;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         live_row_period <= `FSP_ROWP_RST;
         live_exposure <= `FSP_EXPO_RST;
         live_gain <= `FSP_GAIN_RST;
         gain_hold <= `FSP_GAIN_RST;
         gain_hold_v <= 1'b0;
      end
      else
      begin
         live_row_period <= rp_live;
         live_exposure <= ex_live;
         // release first, so a newer gain or a new hold below wins
         if (xfer & gain_hold_v)
         begin
            live_gain <= gain_hold;
            gain_hold_v <= 1'b0;
         end
         if (xfer & gn_dirty & ex_dirty & ~galign)
         begin
            gain_hold <= gn_pend;
            gain_hold_v <= 1'b1;
         end
         else if (xfer & gn_dirty)
            live_gain <= gn_pend;
      end
   end
   // ----------------------------------------------------------------
   // corrupted frame tracking and output valids
   // ----------------------------------------------------------------
   reg bad_cur;
   // row period transfer corrupts the frame it starts
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bad_cur <= 1'b0;
      end
      else if (frame_start)
         bad_cur <= xfer & rp_dirty & (rp_pend != rp_live);
   end
   wire mask;
   assign mask = bad_cur & suppress;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         row_valid <= 1'b0;
         frame_valid_flag <= 1'b0;
      end
      else
      begin
         frame_valid_flag <= streaming & ~mask &
            (row_cnt >= `FSP_DARK_ROWS);
         row_valid <= streaming & ~mask & (row_cnt >= `FSP_DARK_ROWS) &
            (col_cnt < (live_row_period >> 1));
      end
   end
   // ----------------------------------------------------------------
   // read mux: pending copies for synchronised registers
   // ----------------------------------------------------------------
   reg rd_pend;
   reg [7:0] rd_addr;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend <= 1'b0;
         rd_addr <= 8'h00;
      end
      else if (hready)
      begin
         rd_pend <= hsel & htrans[1] & ~hwrite;
         rd_addr <= haddr;
      end
   end
   always @*
   begin
      hrdata = 32'h00000000;
      if (rd_pend)
      begin
         case (rd_addr)
            `FSP_A_CTRL: hrdata = {16'h0000, ctrl};
            `FSP_A_ROWP: hrdata = {16'h0000, rp_pend};
            `FSP_A_EXPO: hrdata = {16'h0000, ex_pend};
            `FSP_A_GAIN: hrdata = {16'h0000, gn_pend};
            `FSP_A_SLOW: hrdata = {16'h0000, slow};
            `FSP_A_PLL: hrdata = {16'h0000, pll};
            `FSP_A_STAT: hrdata = {29'h0, gain_hold_v, bad_cur, frame_valid_flag};
            `FSP_A_LIVE_EXPO: hrdata = {16'h0000, live_exposure};
            `FSP_A_LIVE_GAIN: hrdata = {16'h0000, live_gain};
            `FSP_A_GALIGN: hrdata = {31'h0, galign};
            default: hrdata = 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: fsp_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defines.vh"
// ----------------------------------------------------------------
// checker on the top ports
// ----------------------------------------------------------------
module fsp_top_asserts #(
   parameter ROWS_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic frame_start,
   input wire logic row_valid,
   input wire logic frame_valid_flag,
   input wire logic video_timing_pixel_clock,
   input wire logic core_pixel_tick,
   input wire logic output_pixel_clock,
   input wire logic output_load_clock,
   input wire logic serial_clock_en,
   input wire logic [15:0] live_exposure,
   input wire logic [15:0] live_gain,
   input wire logic [15:0] live_row_period
);
   logic wr_q;
   logic [7:0] a_q;
   logic frz;
   // shadow of the freeze bit, so a hold can be judged from the ports
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         a_q <= 8'h00;
         frz <= 1'b0;
      end
      else
      begin
         wr_q <= hsel && htrans[1] && hready && hwrite;
         a_q <= haddr;
         if (wr_q && a_q == `FSP_A_CTRL)
            frz <= hwdata[`FSP_B_FREEZE];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // three samples cover the one-cycle lag of the live copies
   sequence frozen3;
      frz [*3];
   endsequence
   sequence near_start;
      $past(frame_start) || $past(frame_start, 2);
   endsequence
   freeze_hold_a: assert property (frozen3 |-> $stable(live_gain))
      else $error("live gain moved while frozen");
   live_sync_a: assert property ($changed(live_exposure) |-> near_start)
      else $error("live exposure moved off frame start");
   gain_sync_a: assert property ($changed(live_gain) |-> near_start)
      else $error("live gain moved off frame start");
   row_sync_a: assert property ($changed(live_row_period) |-> near_start)
      else $error("row period moved off frame start");
   vt_half_a: assert property (video_timing_pixel_clock |=> !video_timing_pixel_clock)
      else $error("video timing tick not halved");
   core_div_a: assert property (core_pixel_tick |-> video_timing_pixel_clock)
      else $error("core tick without video tick");
   load_div_a: assert property (output_load_clock |-> output_pixel_clock)
      else $error("load tick without output tick");
   standby_gate_a: assert property (!serial_clock_en [*2] |-> !video_timing_pixel_clock)
      else $error("tick running in standby");
   row_in_frame_a: assert property (row_valid |-> frame_valid_flag)
      else $error("row valid outside frame");
   start_pulse_a: assert property (frame_start |=> !frame_start)
      else $error("frame start longer than a cycle");
endmodule
bind fsp_top fsp_top_asserts #(.ROWS_W(ROWS_W)) i_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hwdata(hwdata), .frame_start(frame_start), .row_valid(row_valid),
   .frame_valid_flag(frame_valid_flag), .video_timing_pixel_clock(video_timing_pixel_clock),
   .core_pixel_tick(core_pixel_tick), .output_pixel_clock(output_pixel_clock),
   .output_load_clock(output_load_clock), .serial_clock_en(serial_clock_en),
   .live_exposure(live_exposure), .live_gain(live_gain), .live_row_period(live_row_period));
`default_nettype wire

// file: fsp_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// host model: single word transfers on the register bus
// ----------------------------------------------------------------
module fsp_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic stuck
);
   // idle bus from time zero
   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata, stuck} = '0;
      hsize = 3'h2;
   end
   // hready and read data are taken at the rising edge, before its updates land
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      logic r;
      int k;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      k = 0;
      do
      begin
         @(posedge hclk);
         r = hready;
         k++;
      end
      while (!r && k < 64);
      if (!r)
         stuck = 1'b1;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      k = 0;
      do
      begin
         @(posedge hclk);
         r = hready;
         q = hrdata;
         k++;
      end
      while (!r && k < 64);
      if (!r)
         stuck = 1'b1;
   endtask
endmodule
`default_nettype wire

// file: test_frame_sync_parameter_update.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defines.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module test_frame_sync_parameter_update;
   logic hclk, hresetn, hsel, hwrite, hreadyout, stuck, fs, rv, fv, vt, sce;
   logic hresp_s, cpt, opc, olc, wclk;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [15:0] lrow, lexp, lgain;
   int checks, miscompares, n;
   logic seen;
   fsp_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .stuck(stuck));
   fsp_top #(.ROWS_W(16)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp_s),
      .frame_start(fs), .row_valid(rv), .frame_valid_flag(fv),
      .video_timing_pixel_clock(vt), .core_pixel_tick(cpt), .output_pixel_clock(opc),
      .output_load_clock(olc), .word_clock(wclk), .serial_clock_en(sce),
      .live_row_period(lrow), .live_exposure(lexp), .live_gain(lgain));
   // free-running clock
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_host.xfer(1'b1, a, {16'h0000, d}, rd);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      i_host.xfer(1'b0, a, 32'h0, rd);
      `CHK(rd, e)
   endtask
   // next frame start, noting any valid output on the way; a hang ends the run
   task automatic wait_fs();
      seen = 1'b0;
      n = 0;
      do begin @(negedge hclk); seen |= rv | fv; n++; end while (fs !== 1'b1 && n < 20000);
      if (fs !== 1'b1)
      begin
         miscompares++;
         final_report();
      end
      repeat (3) @(negedge hclk);
   endtask
   task automatic t_reset();
      `CHK(lexp, 16'h0004)
      `CHK(lgain, 16'h0010)
      `CHK(lrow, 16'h0010)
      rdc(`FSP_A_CTRL, 32'h0200);
      rdc(`FSP_A_SLOW, 32'h0101);
      rdc(8'h3c, 32'h0);
   endtask
   task automatic t_pending();
      wr(`FSP_A_EXPO, 16'h0030);
      rdc(`FSP_A_EXPO, 32'h0030);
      `CHK(lexp, 16'h0004)
      wr(`FSP_A_CTRL, 16'h0204);
      wait_fs();
      `CHK(lexp, 16'h0030)
   endtask
   task automatic t_freeze();
      wr(`FSP_A_CTRL, 16'h8204);
      wr(`FSP_A_GAIN, 16'h0020);
      wait_fs();
      wait_fs();
      `CHK(lgain, 16'h0010)
      wr(`FSP_A_CTRL, 16'h0204);
      wait_fs();
      `CHK(lgain, 16'h0020)
      wr(`FSP_A_GAIN, 16'h0030);
      wait_fs();
      `CHK(lgain, 16'h0030)
   endtask
   task automatic t_expo_gain();
      wr(`FSP_A_EXPO, 16'h0050);
      wr(`FSP_A_GAIN, 16'h0040);
      wait_fs();
      `CHK(lexp, 16'h0050)
      `CHK(lgain, 16'h0030)
      wait_fs();
      `CHK(lgain, 16'h0040)
      wr(`FSP_A_GALIGN, 16'h0001);
      wr(`FSP_A_EXPO, 16'h0060);
      wr(`FSP_A_GAIN, 16'h0050);
      wait_fs();
      `CHK(lgain, 16'h0050)
      `CHK(lexp, 16'h0060)
   endtask
   task automatic t_bad();
      wr(`FSP_A_ROWP, 16'h0018);
      wait_fs();
      `CHK(lrow, 16'h0018)
      wait_fs();
      `CHK(seen, 1'b0)
      wait_fs();
      `CHK(seen, 1'b1)
      wr(`FSP_A_CTRL, 16'h0004);
      wr(`FSP_A_ROWP, 16'h0010);
      wait_fs();
      wait_fs();
      `CHK(seen, 1'b1)
   endtask
   task automatic t_standby();
      wr(`FSP_A_CTRL, 16'h0200);
      repeat (4) @(negedge hclk);
      n = 0;
      repeat (200) @(negedge hclk) n += vt;
      `CHK(n, 0)
      `CHK(sce, 1'b0)
      wr(`FSP_A_PLL, 16'h0202);
      rdc(`FSP_A_PLL, 32'h0202);
      repeat (50) @(posedge hclk);
      wr(`FSP_A_CTRL, 16'h0204);
      wait_fs();
      `CHK(sce, 1'b1)
   endtask
   // tick ratios over a whole number of periods of every enable
   task automatic t_clocks();
      int c_vt = 0;
      int c_core = 0;
      int c_op = 0;
      int c_load = 0;
      int c_word = 0;
      wr(`FSP_A_SLOW, 16'h0203);
      wr(`FSP_A_CTRL, 16'h0214);
      repeat (8) @(negedge hclk);
      repeat (240)
      begin
         @(negedge hclk);
         c_vt += vt;
         c_core += cpt;
         c_op += opc;
         c_load += olc;
         c_word += wclk;
      end
      `CHK(c_vt, 60)
      `CHK(c_core, 20)
      `CHK(c_op, 120)
      `CHK(c_load, 60)
      `CHK(c_word, 30)
      `CHK(hresp_s, 1'b0)
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      checks = 0;
      miscompares = 0;
      hresetn = 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_pending();
      t_freeze();
      t_expo_gain();
      t_bad();
      t_standby();
      t_clocks();
      `CHK(stuck, 1'b0)
      final_report();
   end
endmodule
`default_nettype wire
